// >>> shared/line_ctrl_regs.vh
// Purpose: register indices, field positions, reset values and timing for the UART line control block
// Assumes: byte address on the bus is four times the register index
// Notes: registers are at most 16 bits wide, in the low half of a 32-bit word
`ifndef LINE_CTRL_REGS_VH
`define LINE_CTRL_REGS_VH

`define IDX_RESUME_CHAR 10'h047
`define IDX_PAUSE_CHAR 10'h048
`define IDX_ERROR_FLAGS 10'h049
`define IDX_BREAK_COUNT 10'h04a
`define IDX_RELEASE_DELAY 10'h04b
`define IDX_PIN_FUNCTION 10'h04c
`define IDX_PIN_OUTPUT_SEL 10'h04d
`define IDX_PIN_DRIVE_HIGH 10'h04e
`define IDX_PIN_DRIVE_LOW 10'h04f
`define IDX_PIN_LEVEL 10'h050
`define IDX_PIN_INT_MASK 10'h051

`define RST_RESUME_CHAR 8'h11
`define RST_PAUSE_CHAR 8'h13

`define ERR_BREAK_LIVE 7
`define ERR_OVERRUN 6
`define ERR_PARITY 5
`define ERR_FRAMING 4
`define ERR_BREAK_SEEN 3

`define BREAK_FOREVER 16'hffff
`define FN_POL_BIT 3

`define MODE_GPIO 3'h0
`define MODE_RTS_CTS 3'h1
`define MODE_DTR_DSR 3'h2
`define MODE_485_TX 3'h3
`define MODE_485_ADDR 3'h4

`define BREAK_TICK_US 1000
`define CLK_MHZ 10

`endif

// >>> verilog/uart_line_ctrl_gpio.v
// Purpose: UART line control, break timer, RS-485 direction and six shared GPIO pins
// Assumes: Avalon-MM slave, word addressed by register index; pin and line inputs are asynchronous
// Notes: registers answer with waitrequest low one cycle after the request appears
`timescale 1ns/100ps
`include "line_ctrl_regs.vh"

module uart_line_ctrl_gpio #(
    parameter BREAK_TICK_CYCLES = (`BREAK_TICK_US * `CLK_MHZ),
    parameter PIN_COUNT = 6
) (
    input wire CLK_IN,
    input wire RESET_N_IN,
    input wire [9:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    output reg [31:0] AVS_READDATA_OUT,
    output reg AVS_WAITREQUEST_OUT,
    input wire [8:0] RX_CHAR_IN,
    input wire RX_CHAR_VALID_IN,
    input wire RX_BREAK_LINE_IN,
    input wire RX_OVERRUN_IN,
    input wire RX_PARITY_ERR_IN,
    input wire RX_FRAMING_ERR_IN,
    input wire RX_BREAK_ERR_IN,
    input wire TX_BUSY_IN,
    input wire BIT_TICK_IN,
    input wire ADDRESS_MATCH_IN,
    output reg TX_BREAK_OUT,
    output reg RESUME_SEEN_OUT,
    output reg PAUSE_SEEN_OUT,
    output reg PEER_CTS_OUT,
    output reg PEER_DSR_OUT,
    input wire LOCAL_RTS_IN,
    input wire LOCAL_DTR_IN,
    input wire [5:0] PIN_IN,
    output reg [5:0] PIN_OUT,
    output reg [5:0] PIN_OE_OUT,
    output reg PIN_CHANGE_OUT
);

    reg [7:0] resume_char_q;
    reg [7:0] pause_char_q;
    reg [3:0] err_sticky_q;
    reg [15:0] break_count_q;
    reg [23:0] tick_cnt_q;
    reg [3:0] release_delay_q;
    reg [3:0] pin_function_q;
    reg [5:0] pin_output_sel_q;
    reg [5:0] pin_latch_q;
    reg [5:0] pin_int_mask_q;
    reg [5:0] pin_meta_q;
    reg [5:0] pin_sync_q;
    reg [5:0] pin_prev_q;
    reg [4:0] err_meta_q;
    reg [4:0] err_sync_q;
    reg [4:0] err_prev_q;
    reg busy_meta_q;
    reg busy_sync_q;
    reg match_meta_q;
    reg match_sync_q;
    reg bit_meta_q;
    reg bit_sync_q;
    reg bit_prev_q;
    reg dir_active_q;
    reg [3:0] hold_cnt_q;
    reg addr_armed_q;
    reg [7:0] rx_char_q;
    reg rx_new_q;
    reg [1:0] pin_settle_q;
    reg rx_valid_meta_q;
    reg rx_valid_sync_q;
    reg rx_valid_prev_q;
    reg [31:0] rdata_d;
    reg [5:0] pin_out_d;
    reg [5:0] pin_oe_d;

    wire access = (AVS_READ_IN | AVS_WRITE_IN) & AVS_WAITREQUEST_OUT;
    wire wr = AVS_WRITE_IN & AVS_WAITREQUEST_OUT;
    wire rd = AVS_READ_IN & AVS_WAITREQUEST_OUT;
    wire lo_en = AVS_BYTEENABLE_IN[0];
    wire hi_en = AVS_BYTEENABLE_IN[1];
    wire [15:0] wdata = AVS_WRITEDATA_IN[15:0];
    wire [2:0] mode = pin_function_q[2:0];
    wire pol_high = pin_function_q[`FN_POL_BIT];
    // Last count of one millisecond, cut to the width of the counter
    wire [31:0] tick_last = BREAK_TICK_CYCLES - 1;
    wire tick_done = (tick_cnt_q == tick_last[23:0]);
    wire rx_valid_rise = rx_valid_sync_q & ~rx_valid_prev_q;
    wire bit_rise = bit_sync_q & ~bit_prev_q;
    wire [3:0] err_rise = err_sync_q[3:0] & ~err_prev_q[3:0];
    wire is_485 = (mode == `MODE_485_TX) | (mode == `MODE_485_ADDR);
    wire [15:0] break_wr = {hi_en ? wdata[15:8] : break_count_q[15:8], lo_en ? wdata[7:0] : break_count_q[7:0]};

    // Two-flop synchronisers for everything that arrives from the line side except the character, which is captured on its valid edge
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            pin_meta_q <= 6'h00;
            pin_sync_q <= 6'h00;
            pin_prev_q <= 6'h00;
            pin_settle_q <= 2'h0;
            err_meta_q <= 5'h00;
            err_sync_q <= 5'h00;
            err_prev_q <= 5'h00;
            busy_meta_q <= 1'b0;
            busy_sync_q <= 1'b0;
            match_meta_q <= 1'b0;
            match_sync_q <= 1'b0;
            bit_meta_q <= 1'b0;
            bit_sync_q <= 1'b0;
            bit_prev_q <= 1'b0;
            rx_valid_meta_q <= 1'b0;
            rx_valid_sync_q <= 1'b0;
            rx_valid_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= PIN_IN;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
            // Pulled-up pins would look like a change right after reset; wait until the pipe holds real levels
            if (pin_settle_q != 2'h3) begin
                pin_settle_q <= pin_settle_q + 2'h1;
            end
            err_meta_q <= {RX_BREAK_LINE_IN, RX_OVERRUN_IN, RX_PARITY_ERR_IN, RX_FRAMING_ERR_IN, RX_BREAK_ERR_IN};
            err_sync_q <= err_meta_q;
            err_prev_q <= err_sync_q;
            busy_meta_q <= TX_BUSY_IN;
            busy_sync_q <= busy_meta_q;
            match_meta_q <= ADDRESS_MATCH_IN;
            match_sync_q <= match_meta_q;
            bit_meta_q <= BIT_TICK_IN;
            bit_sync_q <= bit_meta_q;
            bit_prev_q <= bit_sync_q;
            rx_valid_meta_q <= RX_CHAR_VALID_IN;
            rx_valid_sync_q <= rx_valid_meta_q;
            rx_valid_prev_q <= rx_valid_sync_q;
        end
    end

    // Character is sampled once its valid level has crossed, so it is stable by then
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            rx_char_q <= 8'h00;
            rx_new_q <= 1'b0;
            RESUME_SEEN_OUT <= 1'b0;
            PAUSE_SEEN_OUT <= 1'b0;
        end else begin
            if (rx_valid_rise) begin
                rx_char_q <= RX_CHAR_IN[7:0];
            end
            // Compare one cycle later, against the captured copy
            rx_new_q <= rx_valid_rise;
            RESUME_SEEN_OUT <= rx_new_q & (rx_char_q == resume_char_q);
            PAUSE_SEEN_OUT <= rx_new_q & (rx_char_q == pause_char_q);
        end
    end

    // Register bus: one wait cycle, then the answer
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_READDATA_OUT <= 32'h00000000;
        end else begin
            AVS_WAITREQUEST_OUT <= ~access;
            if (rd) begin
                AVS_READDATA_OUT <= rdata_d;
            end
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        case (AVS_ADDRESS_IN)
            `IDX_RESUME_CHAR: rdata_d[7:0] = resume_char_q;
            `IDX_PAUSE_CHAR: rdata_d[7:0] = pause_char_q;
            `IDX_ERROR_FLAGS: rdata_d[7:3] = {err_sync_q[4], err_sticky_q};
            `IDX_BREAK_COUNT: rdata_d[15:0] = break_count_q;
            `IDX_RELEASE_DELAY: rdata_d[3:0] = release_delay_q;
            `IDX_PIN_FUNCTION: rdata_d[3:0] = pin_function_q;
            `IDX_PIN_OUTPUT_SEL: rdata_d[5:0] = pin_output_sel_q;
            `IDX_PIN_LEVEL: rdata_d[5:0] = pin_sync_q;
            `IDX_PIN_INT_MASK: rdata_d[5:0] = pin_int_mask_q;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Configuration registers and sticky error flags
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            resume_char_q <= `RST_RESUME_CHAR;
            pause_char_q <= `RST_PAUSE_CHAR;
            release_delay_q <= 4'h0;
            pin_function_q <= 4'h0;
            pin_output_sel_q <= 6'h00;
            pin_int_mask_q <= 6'h00;
            err_sticky_q <= 4'h0;
        end else begin
            if (wr && lo_en) begin
                case (AVS_ADDRESS_IN)
                    `IDX_RESUME_CHAR: resume_char_q <= wdata[7:0];
                    `IDX_PAUSE_CHAR: pause_char_q <= wdata[7:0];
                    `IDX_RELEASE_DELAY: release_delay_q <= wdata[3:0];
                    `IDX_PIN_FUNCTION: pin_function_q <= wdata[3:0];
                    `IDX_PIN_OUTPUT_SEL: pin_output_sel_q <= wdata[5:0];
                    `IDX_PIN_INT_MASK: pin_int_mask_q <= wdata[5:0];
                    default: ;
                endcase
            end
            // A new error in the read cycle survives the clear
            if (rd && AVS_ADDRESS_IN == `IDX_ERROR_FLAGS) begin
                err_sticky_q <= err_rise;
            end else begin
                err_sticky_q <= err_sticky_q | err_rise;
            end
        end
    end

    // Break generator with millisecond countdown
    // A fresh write restarts the millisecond so the first step is a whole one
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            break_count_q <= 16'h0000;
            tick_cnt_q <= 24'h000000;
            TX_BREAK_OUT <= 1'b0;
        end else begin
            if (wr && AVS_ADDRESS_IN == `IDX_BREAK_COUNT && (lo_en || hi_en)) begin
                break_count_q <= break_wr;
                tick_cnt_q <= 24'h000000;
            end else if (break_count_q != 16'h0000 && break_count_q != `BREAK_FOREVER) begin
                if (tick_done) begin
                    tick_cnt_q <= 24'h000000;
                    break_count_q <= break_count_q - 16'h0001;
                end else begin
                    tick_cnt_q <= tick_cnt_q + 24'h000001;
                end
            end
            TX_BREAK_OUT <= (break_count_q != 16'h0000);
        end
    end

    // RS-485 direction: asserted while sending (in MODE_485_ADDR only after an address match), held for the release delay in bit times
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            dir_active_q <= 1'b0;
            hold_cnt_q <= 4'h0;
            addr_armed_q <= 1'b0;
        end else begin
            if (mode != `MODE_485_ADDR) begin
                addr_armed_q <= 1'b0;
            end else if (match_sync_q) begin
                addr_armed_q <= 1'b1;
            end
            if (!is_485) begin
                dir_active_q <= 1'b0;
                hold_cnt_q <= 4'h0;
            end else if (busy_sync_q && (mode == `MODE_485_TX || addr_armed_q)) begin
                dir_active_q <= 1'b1;
                hold_cnt_q <= release_delay_q;
            end else if (dir_active_q) begin
                if (hold_cnt_q == 4'h0) begin
                    dir_active_q <= 1'b0;
                end else if (bit_rise) begin
                    hold_cnt_q <= hold_cnt_q - 4'h1;
                end
            end
        end
    end

    // GPIO output latches
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            pin_latch_q <= 6'h00;
        end else if (wr && lo_en) begin
            if (AVS_ADDRESS_IN == `IDX_PIN_DRIVE_HIGH) begin
                pin_latch_q <= pin_latch_q | (wdata[5:0] & pin_output_sel_q);
            end else if (AVS_ADDRESS_IN == `IDX_PIN_DRIVE_LOW) begin
                pin_latch_q <= pin_latch_q & ~(wdata[5:0] & pin_output_sel_q);
            end
        end
    end

    // Pin function mux: start from GPIO, then let the mode take over its pins
    always @* begin
        pin_out_d = pin_latch_q;
        pin_oe_d = pin_output_sel_q;
        case (mode)
            `MODE_RTS_CTS: begin
                pin_out_d[5] = ~LOCAL_RTS_IN;
                pin_oe_d[5] = 1'b1;
                pin_oe_d[4] = 1'b0;
            end
            `MODE_DTR_DSR: begin
                pin_out_d[3] = ~LOCAL_DTR_IN;
                pin_oe_d[3] = 1'b1;
                pin_oe_d[2] = 1'b0;
            end
            `MODE_485_TX, `MODE_485_ADDR: begin
                pin_out_d[5] = pol_high ? dir_active_q : ~dir_active_q;
                pin_oe_d[5] = 1'b1;
            end
            default: ;
        endcase
    end

    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            PIN_OUT <= 6'h00;
            PIN_OE_OUT <= 6'h00;
            PEER_CTS_OUT <= 1'b0;
            PEER_DSR_OUT <= 1'b0;
            PIN_CHANGE_OUT <= 1'b0;
        end else begin
            PIN_OUT <= pin_out_d;
            PIN_OE_OUT <= pin_oe_d;
            PEER_CTS_OUT <= (mode == `MODE_RTS_CTS) & ~pin_sync_q[4];
            PEER_DSR_OUT <= (mode == `MODE_DTR_DSR) & ~pin_sync_q[2];
            PIN_CHANGE_OUT <= (pin_settle_q == 2'h3) && (|((pin_sync_q ^ pin_prev_q) & ~pin_int_mask_q));
        end
    end

endmodule // uart_line_ctrl_gpio

// >>> test/line_ctrl_props.sv
// Purpose: port-level checks of the line control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every instance of the block
`timescale 1ns/100ps
`include "line_ctrl_regs.vh"
module line_ctrl_props #(parameter BREAK_TICK_CYCLES = 10) (
    input wire CLK_IN,
    input wire RESET_N_IN,
    input wire [9:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    input wire [31:0] AVS_READDATA_OUT,
    input wire AVS_WAITREQUEST_OUT,
    input wire TX_BREAK_OUT,
    input wire [5:0] PIN_OUT,
    input wire [5:0] PIN_OE_OUT,
    input wire PIN_CHANGE_OUT
);
    localparam int BRK_LO = BREAK_TICK_CYCLES;
    localparam int BRK_HI = 2 * BREAK_TICK_CYCLES + 4;
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    wire wr_ok = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0];
    wire [15:0] wd = AVS_WRITEDATA_IN[15:0];
    wire brk_wr = wr_ok && AVS_ADDRESS_IN == `IDX_BREAK_COUNT && AVS_BYTEENABLE_IN[1];
    a_wait_answer: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
        else $error("request not answered in one cycle");
    a_wait_one: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");
    a_upper_zero: assert property (!AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_break_hold: assert property (brk_wr && wd == `BREAK_FOREVER |-> ##3 TX_BREAK_OUT [*6])
        else $error("untimed break dropped");
    a_break_stop: assert property (brk_wr && wd == 16'h0 |-> ##3 !TX_BREAK_OUT)
        else $error("break not stopped by zero");
    a_break_timed: assert property (brk_wr && wd == 16'h2 |-> ##[BRK_LO:BRK_HI] $fell(TX_BREAK_OUT))
        else $error("timed break length wrong");
    a_dir_follows: assert property (wr_ok && AVS_ADDRESS_IN == `IDX_PIN_OUTPUT_SEL
        |-> ##3 {14'h0, PIN_OE_OUT[1:0]} == ($past(wd, 3) & 16'h3))
        else $error("pin direction not taken");
    a_set_high: assert property (wr_ok && AVS_ADDRESS_IN == `IDX_PIN_DRIVE_HIGH && wd[0] && PIN_OE_OUT[0]
        |-> ##3 PIN_OUT[0])
        else $error("set did not drive high");
    a_clear_low: assert property (wr_ok && AVS_ADDRESS_IN == `IDX_PIN_DRIVE_LOW && wd[0] && PIN_OE_OUT[0]
        |-> ##3 !PIN_OUT[0])
        else $error("clear did not drive low");
    a_change_pulse: assert property (PIN_CHANGE_OUT |=> !PIN_CHANGE_OUT)
        else $error("pin change pulse too long");
    c_break: cover property (brk_wr);
    c_flags: cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == `IDX_ERROR_FLAGS);
    c_change: cover property (PIN_CHANGE_OUT);
endmodule // line_ctrl_props
bind uart_line_ctrl_gpio line_ctrl_props #(.BREAK_TICK_CYCLES(BREAK_TICK_CYCLES)) props (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
    .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .TX_BREAK_OUT(TX_BREAK_OUT),
    .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PIN_CHANGE_OUT(PIN_CHANGE_OUT));

// >>> test/pin_pad_model.sv
// Purpose: far-side pads of the six shared pins
// Assumes: the peer drives only pins that the block leaves as inputs
// Notes: an undriven pin floats to its pull-up
`timescale 1ns/100ps
module pin_pad_model (
    input wire [5:0] drive_in,
    input wire [5:0] oe_in,
    input wire [5:0] ext_in,
    input wire [5:0] ext_en_in,
    output wire [5:0] level_out
);
    // Pull-up only on pins that are inputs
    assign level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_in) | (~oe_in & ~ext_en_in);
endmodule // pin_pad_model

// >>> test/uart_line_ctrl_gpio_bench.sv
// Purpose: register-level tests of the line control block
// Assumes: one access answered within a few cycles
// Notes: break tick shortened to 10 cycles
`timescale 1ns/100ps
`include "line_ctrl_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module uart_line_ctrl_gpio_bench;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, vld = 0, brk = 0, busy = 0, tick = 0, match = 0, rts = 0, dtr = 0;
    logic [9:0] adr = 0;
    logic [31:0] wd = 0, rdata;
    logic [8:0] ch = 0;
    logic [3:0] err = 0;
    logic [5:0] ext = 0, ext_en = 0, pin_lvl, pout, poe;
    logic wait_o, brk_o, res_o, pau_o, cts_o, dsr_o, chg_o;
    logic [15:0] q;
    logic [15:0] rst_v [12] = '{16'h11, 16'h13, 0, 0, 0, 0, 0, 0, 0, 16'h3f, 0, 0};
    int fails = 0, samples_checked = 0, cycles = 0, n_chg = 0, c0;
    uart_line_ctrl_gpio #(.BREAK_TICK_CYCLES(10), .PIN_COUNT(6)) DUT (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_o),
        .RX_CHAR_IN(ch), .RX_CHAR_VALID_IN(vld), .RX_BREAK_LINE_IN(brk), .RX_OVERRUN_IN(err[3]),
        .RX_PARITY_ERR_IN(err[2]), .RX_FRAMING_ERR_IN(err[1]), .RX_BREAK_ERR_IN(err[0]), .TX_BUSY_IN(busy),
        .BIT_TICK_IN(tick), .ADDRESS_MATCH_IN(match), .TX_BREAK_OUT(brk_o), .RESUME_SEEN_OUT(res_o),
        .PAUSE_SEEN_OUT(pau_o), .PEER_CTS_OUT(cts_o), .PEER_DSR_OUT(dsr_o), .LOCAL_RTS_IN(rts),
        .LOCAL_DTR_IN(dtr), .PIN_IN(pin_lvl), .PIN_OUT(pout), .PIN_OE_OUT(poe), .PIN_CHANGE_OUT(chg_o));
    pin_pad_model pads (.drive_in(pout), .oe_in(poe), .ext_in(ext), .ext_en_in(ext_en), .level_out(pin_lvl));
    initial forever #50 clk = ~clk;
    task close_out;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (chg_o === 1'b1) n_chg++;
        if (cycles > 4000) begin
            fails++;
            close_out();
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One access; settles four cycles so pin levels resync before the next
    task bus(input logic r, input logic [9:0] a, input logic [15:0] d);
        adr <= a;
        wd <= {16'h0, d};
        rd <= r;
        wr <= !r;
        @(posedge clk);
        while (wait_o !== 1'b0) @(posedge clk);
        q = rdata[15:0];
        rd <= 0;
        wr <= 0;
        cyc(4);
    endtask
    task w(input logic [9:0] a, input logic [15:0] d);
        bus(0, a, d);
    endtask
    task rc(input logic [9:0] a, input logic [15:0] e);
        bus(1, a, 16'h0);
        `CHK(q, e)
    endtask
    task wrc(input logic [9:0] a, input logic [15:0] d, input logic [15:0] e);
        w(a, d);
        rc(a, e);
    endtask
    task chr(input logic [8:0] c, input logic er, input logic ep);
        logic sr, sp;
        sr = 0;
        sp = 0;
        ch <= c;
        vld <= 1;
        repeat (6) begin
            @(posedge clk);
            sr |= res_o;
            sp |= pau_o;
        end
        vld <= 0;
        cyc(3);
        `CHK({sr, sp}, {er, ep})
    endtask
    task errs(input logic [3:0] v, input logic b, input logic [15:0] e);
        err <= v;
        brk <= b;
        cyc(5);
        err <= 4'h0;
        cyc(4);
        rc(`IDX_ERROR_FLAGS, e);
        rc(`IDX_ERROR_FLAGS, {8'h0, b, 7'h0});
        brk <= 0;
    endtask
    task tk(input int n);
        repeat (n) begin
            tick <= 1;
            cyc(3);
            tick <= 0;
            cyc(3);
        end
    endtask
    initial begin
        cyc(2);
        rst_n <= 1;
        @(posedge clk);
        for (int i = 0; i < 12; i++) rc(10'(10'h047 + i), rst_v[i]);
        wrc(`IDX_RESUME_CHAR, 16'hffa5, 16'h00a5);
        wrc(`IDX_PAUSE_CHAR, 16'hff3c, 16'h003c);
        wrc(`IDX_RELEASE_DELAY, 16'hfff2, 16'h0002);
        wrc(`IDX_ERROR_FLAGS, 16'h00f8, 16'h0000);
        chr(9'h0a5, 1, 0);
        chr(9'h13c, 0, 1);
        chr(9'h011, 0, 0);
        errs(4'b1010, 0, 16'h0050);
        errs(4'b0101, 1, 16'h00a8);
        errs(4'b0000, 0, 16'h0000);
        w(`IDX_BREAK_COUNT, 16'hffff);
        cyc(40);
        rc(`IDX_BREAK_COUNT, 16'hffff);
        w(`IDX_BREAK_COUNT, 16'h0003);
        cyc(12);
        `CHK(brk_o, 1'b1)
        cyc(30);
        `CHK(brk_o, 1'b0)
        w(`IDX_BREAK_COUNT, 16'h0002);
        cyc(35);
        rc(`IDX_BREAK_COUNT, 16'h0000);
        w(`IDX_BREAK_COUNT, 16'hffff);
        `CHK(brk_o, 1'b1)
        cyc(4);
        w(`IDX_BREAK_COUNT, 16'h0000);
        `CHK(brk_o, 1'b0)
        w(`IDX_PIN_OUTPUT_SEL, 16'hffff);
        w(`IDX_PIN_DRIVE_HIGH, 16'h0015);
        w(`IDX_PIN_DRIVE_LOW, 16'h0005);
        rc(`IDX_PIN_LEVEL, 16'h0010);
        w(`IDX_PIN_OUTPUT_SEL, 16'h000f);
        w(`IDX_PIN_DRIVE_HIGH, 16'h0020);
        w(`IDX_PIN_DRIVE_LOW, 16'h0010);
        `CHK(poe, 6'h0f)
        w(`IDX_PIN_OUTPUT_SEL, 16'h003f);
        `CHK(pout, 6'h10)
        w(`IDX_PIN_OUTPUT_SEL, 16'h0000);
        c0 = n_chg;
        ext <= 6'h2a;
        ext_en <= 6'h3f;
        cyc(6);
        rc(`IDX_PIN_LEVEL, 16'h002a);
        `CHK(n_chg != c0, 1'b1)
        w(`IDX_PIN_INT_MASK, 16'h003f);
        c0 = n_chg;
        ext <= 6'h00;
        cyc(6);
        `CHK(n_chg != c0, 1'b0)
        rc(`IDX_PIN_LEVEL, 16'h0000);
        w(`IDX_PIN_FUNCTION, 16'h0001);
        rts <= 1;
        cyc(5);
        `CHK({poe[5], pout[5], cts_o}, 3'b101)
        w(`IDX_PIN_FUNCTION, 16'h0002);
        dtr <= 1;
        cyc(5);
        `CHK({poe[3], pout[3], dsr_o}, 3'b101)
        w(`IDX_PIN_FUNCTION, 16'h000b);
        busy <= 1;
        cyc(5);
        `CHK({poe[5], pout[5]}, 2'b11)
        busy <= 0;
        cyc(4);
        tk(1);
        `CHK(pout[5], 1'b1)
        tk(1);
        `CHK(pout[5], 1'b0)
        w(`IDX_PIN_FUNCTION, 16'h0003);
        `CHK(pout[5], 1'b1)
        busy <= 1;
        w(`IDX_PIN_FUNCTION, 16'h000c);
        `CHK(pout[5], 1'b0)
        match <= 1;
        cyc(6);
        `CHK(pout[5], 1'b1)
        close_out();
    end
endmodule // uart_line_ctrl_gpio_bench
